// ### hdl/usart_defines.vh
/*
 Register offsets, field positions, reset values and sample timing for the
 asynchronous serial port receive side, address filter and data buffer.
 Assumes it is included by bare name from the design files under hdl/.
*/
// Overview of operation
// - receiver takes 16 samples per bit, or 8 in double speed
// - first vote sample is 8 in normal speed, 4 in double speed
// - middle vote sample is 9 in normal speed, 5 in double speed
// - receiver accepts 5 to 10 data plus parity bits per frame
// - each end should keep its rate error to half the tolerable total
// - with filtering enabled, frames that are not addresses are discarded
// - transmitter ignores the address filter enable entirely
// - for 5 to 8 data bits the first stop bit marks the frame type
// - for nine data bits the received ninth bit marks the frame type
// - frame type one means address frame, zero means data frame
// - an address frame is stored and raises receive complete; software decides
// - selected slave takes data frames, then re-enables filtering afterwards
// - one data address: writes fill transmit buffer, reads return receive buffer
// - unused upper bits are ignored on transmit and read as zero on receive
// - data writes while the transmit buffer is full are discarded
// - buffered data moves to the empty shifter and is sent on the pin
// - receive buffer is a two-entry FIFO advanced by every data read
// - double speed halves the per-bit divisor from 16 to 8
// - start bit votes samples 8,9,10 or 4,5,6; high majority rejects it
// - transmit complete clears on interrupt service or writing one to it
`ifndef USART_DEFINES_VH
`define USART_DEFINES_VH

// register addresses in the I/O space
`define ADDR_CTRL_A 8'h00
`define ADDR_CTRL_B 8'h01
`define ADDR_CTRL_C 8'h02
`define ADDR_BAUD_LO 8'h04
`define ADDR_BAUD_HI 8'h05
`define ADDR_DATA 8'h06

// status and control A fields
`define A_RXC 7
`define A_TXC 6
`define A_UDRE 5
`define A_FE 4
`define A_DOR 3
`define A_UPE 2
`define A_U2X 1
`define A_MPCM 0

// control B fields
`define B_RXEN 4
`define B_TXEN 3
`define B_UCSZ2 2
`define B_RXB8 1
`define B_TXB8 0

// control C fields
`define C_UPM_HI 5
`define C_UPM_LO 4
`define C_USBS 3
`define C_UCSZ_HI 2
`define C_UCSZ_LO 1

// reset values
`define RESET_CHAR_SIZE 3'h3
`define RESET_BAUD 12'h000

// receive buffer word: overrun, frame error, parity error, ninth bit, data
`define W_DOR 11
`define W_FE 10
`define W_UPE 9
`define W_B8 8
`define RX_WORD_WIDTH 12
`define RX_FIFO_DEPTH 2
`define RX_FIFO_AW 1

// sample timing in sample ticks
`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define FIRST_NORMAL 5'h08
`define FIRST_DOUBLE 5'h04
`define MID_NORMAL 5'h09
`define MID_DOUBLE 5'h05

`endif

// ### hdl/rx_word_fifo.v
/*
 Small synchronous FIFO with valid/ready on both sides and a flush.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_word_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 2,
	parameter AW = 1
) (
	input wire clock,
	input wire srst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage write
	always @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap at the depth
	always @(posedge clock) begin
		if (srst | flush) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/sample_tick_gen.v
/*
 Sample tick divider: one-cycle pulse every divisor+1 clocks.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen (
	input wire clock,
	input wire srst,
	input wire [11:0] divisor,
	output reg tick
);
	reg [11:0] count_reg;

	// count down, pulse and reload at zero
	always @(posedge clock) begin
		if (srst) begin
			count_reg <= 12'h000;
			tick <= 1'b0;
		end else if (count_reg == 12'h000) begin
			count_reg <= divisor;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg - 12'h001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### hdl/usart_rx_address_filter_data_buffer.v
/*
 Asynchronous serial port: majority-vote receiver with address frame
 filter, two-entry receive buffer, transmit holding buffer and shifter,
 and the I/O registers that reach them.
 Assumes a CPU I/O strobe interface synchronous to clock and a receive
 pin already synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.vh"
module usart_rx_address_filter_data_buffer (
	input wire clock,
	input wire srst,
	input wire [7:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	input wire serial_rx_pin,
	output reg serial_tx_pin,
	input wire txc_irq_ack
);
	localparam RX_IDLE = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_DATA = 4'b0100;
	localparam RX_STOP = 4'b1000;

	// character size code to data bits: 0..3 give 5..8, 7 gives 9
	function [3:0] char_bits;
		input [2:0] code;
		begin
			case (code)
				3'h0: char_bits = 4'h5;
				3'h1: char_bits = 4'h6;
				3'h2: char_bits = 4'h7;
				3'h7: char_bits = 4'h9;
				default: char_bits = 4'h8;
			endcase
		end
	endfunction

	// mask of the data bits actually used
	function [8:0] mask9;
		input [3:0] n;
		begin
			mask9 = 9'h1ff >> (4'h9 - n);
		end
	endfunction

	// start bit, data, optional parity, then ones for stop bits
	function [12:0] tx_frame;
		input [8:0] d;
		input [3:0] n;
		input pe;
		input odd;
		reg [11:0] w;
		integer i;
		begin
			w = 12'hfff;
			for (i = 0; i < 9; i = i + 1) begin
				if (i < n) begin
					w[i] = d[i];
				end
			end
			if (pe) begin
				w[n] = ^(d & mask9(n)) ^ odd;
			end
			tx_frame = {w, 1'b0};
		end
	endfunction

	reg u2x_reg;
	reg mpcm_reg;
	reg txc_reg;
	reg rxen_reg;
	reg txen_reg;
	reg [2:0] ucsz_reg;
	reg usbs_reg;
	reg [1:0] upm_reg;
	reg [11:0] baud_reg;
	reg tx_b8_reg;
	reg [8:0] thr_reg;
	reg thr_valid_reg;
	reg [3:0] rx_state_reg;
	reg [4:0] rx_samp_reg;
	reg [1:0] rx_vote_reg;
	reg [3:0] rx_bit_reg;
	reg [9:0] rx_sh_reg;
	reg rx_prev_reg;
	reg pend_valid_reg;
	reg [11:0] pend_word_reg;
	reg ovr_reg;
	reg tx_busy_reg;
	reg [12:0] tx_sh_reg;
	reg [3:0] tx_left_reg;
	reg [4:0] tx_samp_reg;

	wire tick;
	wire fifo_in_ready;
	wire head_valid;
	wire [11:0] head_word;

	// register decode
	wire wr_data = io_wr & (io_addr == `ADDR_DATA);
	wire rd_data = io_rd & (io_addr == `ADDR_DATA);
	wire wr_a = io_wr & (io_addr == `ADDR_CTRL_A);

	// per-mode sample positions
	wire [4:0] s_max = u2x_reg ? `SPB_DOUBLE : `SPB_NORMAL;
	wire [4:0] s_first = u2x_reg ? `FIRST_DOUBLE : `FIRST_NORMAL;
	wire [4:0] s_mid = u2x_reg ? `MID_DOUBLE : `MID_NORMAL;
	wire [4:0] s_cur = (rx_samp_reg == s_max) ? 5'h01 : rx_samp_reg + 5'h01;
	wire decide = tick & (s_cur == s_mid + 5'h01);
	wire vote = (rx_vote_reg[0] & rx_vote_reg[1]) | (rx_vote_reg[0] & serial_rx_pin) |
		(rx_vote_reg[1] & serial_rx_pin);

	// frame format shared by both directions
	wire [3:0] nbits = char_bits(ucsz_reg);
	wire par_en = upm_reg[1];
	wire [3:0] dbits = nbits + {3'h0, par_en};

	// received frame fields, valid while the stop bit is voted
	wire [8:0] rx_data9 = rx_sh_reg[8:0] & mask9(nbits);
	wire rx_upe = par_en & ((^rx_data9 ^ upm_reg[0]) != rx_sh_reg[nbits]);
	wire frame_type = (nbits == 4'h9) ? rx_data9[8] : vote;
	wire keep_frame = ~mpcm_reg | frame_type;

	// transmit side
	wire tx_load = txen_reg & ~tx_busy_reg & thr_valid_reg;
	wire tx_bit_end = tx_busy_reg & tick & (tx_samp_reg == s_max - 5'h01);
	wire tx_done = tx_bit_end & (tx_left_reg == 4'h0);
	wire [3:0] tx_total_m1 = nbits + {3'h0, par_en} + 4'h1 + {3'h0, usbs_reg};

	// sample tick at sixteen or eight per bit time
	sample_tick_gen tick_gen (
		.clock(clock),
		.srst(srst),
		.divisor(baud_reg),
		.tick(tick)
	);

	// two-entry receive buffer, flushed while the receiver is off
	rx_word_fifo #(
		.WIDTH(`RX_WORD_WIDTH),
		.DEPTH(`RX_FIFO_DEPTH),
		.AW(`RX_FIFO_AW)
	) rx_buffer (
		.clock(clock),
		.srst(srst),
		.flush(~rxen_reg),
		.in_valid(pend_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(pend_word_reg),
		.out_valid(head_valid),
		.out_ready(rd_data),
		.out_data(head_word)
	);

	// control register writes
	always @(posedge clock) begin
		if (srst) begin
			u2x_reg <= 1'b0;
			mpcm_reg <= 1'b0;
			rxen_reg <= 1'b0;
			txen_reg <= 1'b0;
			ucsz_reg <= `RESET_CHAR_SIZE;
			usbs_reg <= 1'b0;
			upm_reg <= 2'h0;
			baud_reg <= `RESET_BAUD;
			tx_b8_reg <= 1'b0;
		end else if (io_wr) begin
			case (io_addr)
				`ADDR_CTRL_A: begin
					u2x_reg <= io_wdata[`A_U2X];
					mpcm_reg <= io_wdata[`A_MPCM];
				end
				`ADDR_CTRL_B: begin
					rxen_reg <= io_wdata[`B_RXEN];
					txen_reg <= io_wdata[`B_TXEN];
					ucsz_reg[2] <= io_wdata[`B_UCSZ2];
					tx_b8_reg <= io_wdata[`B_TXB8];
				end
				`ADDR_CTRL_C: begin
					upm_reg <= io_wdata[`C_UPM_HI:`C_UPM_LO];
					usbs_reg <= io_wdata[`C_USBS];
					ucsz_reg[1:0] <= io_wdata[`C_UCSZ_HI:`C_UCSZ_LO];
				end
				`ADDR_BAUD_LO: baud_reg[7:0] <= io_wdata;
				`ADDR_BAUD_HI: baud_reg[11:8] <= io_wdata[3:0];
				default: baud_reg <= baud_reg;
			endcase
		end
	end

	// transmit holding buffer: only taken while empty
	always @(posedge clock) begin
		if (srst) begin
			thr_reg <= 9'h000;
			thr_valid_reg <= 1'b0;
		end else if (wr_data & ~thr_valid_reg) begin
			thr_reg <= {tx_b8_reg, io_wdata} & mask9(nbits);
			thr_valid_reg <= 1'b1;
		end else if (tx_load) begin
			thr_valid_reg <= 1'b0;
		end
	end

	// transmit complete: the set wins over both clears
	always @(posedge clock) begin
		if (srst) begin
			txc_reg <= 1'b0;
		end else if (tx_done & ~thr_valid_reg) begin
			txc_reg <= 1'b1;
		end else if (txc_irq_ack | (wr_a & io_wdata[`A_TXC])) begin
			txc_reg <= 1'b0;
		end
	end

	// transmit shifter, independent of the address filter enable
	always @(posedge clock) begin
		if (srst) begin
			tx_busy_reg <= 1'b0;
			tx_sh_reg <= 13'h1fff;
			tx_left_reg <= 4'h0;
			tx_samp_reg <= 5'h00;
			serial_tx_pin <= 1'b1;
		end else if (tx_load) begin
			tx_busy_reg <= 1'b1;
			tx_sh_reg <= tx_frame(thr_reg, nbits, par_en, upm_reg[0]) >> 1;
			tx_left_reg <= tx_total_m1;
			tx_samp_reg <= 5'h00;
			serial_tx_pin <= 1'b0;
		end else if (tx_busy_reg & tick) begin
			if (tx_bit_end) begin
				tx_samp_reg <= 5'h00;
				if (tx_left_reg == 4'h0) begin
					tx_busy_reg <= 1'b0;
				end else begin
					serial_tx_pin <= tx_sh_reg[0];
					tx_sh_reg <= {1'b1, tx_sh_reg[12:1]};
					tx_left_reg <= tx_left_reg - 4'h1;
				end
			end else begin
				tx_samp_reg <= tx_samp_reg + 5'h01;
			end
		end
	end

	// receiver: start detect, majority vote, frame assembly and filter
	always @(posedge clock) begin
		if (srst | ~rxen_reg) begin
			rx_state_reg <= RX_IDLE;
			rx_samp_reg <= 5'h00;
			rx_vote_reg <= 2'h3;
			rx_bit_reg <= 4'h0;
			rx_sh_reg <= 10'h000;
			rx_prev_reg <= 1'b1;
			pend_valid_reg <= 1'b0;
			pend_word_reg <= 12'h000;
			ovr_reg <= 1'b0;
		end else begin
			if (pend_valid_reg & fifo_in_ready) begin
				pend_valid_reg <= 1'b0;
			end
			if (tick) begin
				rx_prev_reg <= serial_rx_pin;
				case (rx_state_reg)
					RX_IDLE: begin
						// falling edge: this tick is sample one
						if (rx_prev_reg & ~serial_rx_pin) begin
							rx_state_reg <= RX_START;
							rx_samp_reg <= 5'h01;
						end
					end
					RX_START, RX_DATA, RX_STOP: begin
						rx_samp_reg <= s_cur;
						if (s_cur == s_first) begin
							rx_vote_reg[0] <= serial_rx_pin;
						end
						if (s_cur == s_mid) begin
							rx_vote_reg[1] <= serial_rx_pin;
						end
						if (decide) begin
							case (rx_state_reg)
								RX_START: begin
									if (vote) begin
										rx_state_reg <= RX_IDLE;
									end else begin
										rx_state_reg <= RX_DATA;
										rx_bit_reg <= 4'h0;
										// buffer full with a frame waiting: it is lost
										if (pend_valid_reg & ~fifo_in_ready) begin
											ovr_reg <= 1'b1;
											pend_valid_reg <= 1'b0;
										end
									end
								end
								RX_DATA: begin
									rx_sh_reg[rx_bit_reg] <= vote;
									rx_bit_reg <= rx_bit_reg + 4'h1;
									if (rx_bit_reg == dbits - 4'h1) begin
										rx_state_reg <= RX_STOP;
									end
								end
								RX_STOP: begin
									rx_state_reg <= RX_IDLE;
									// dropped frames store nothing; an overrun set at their start bit stays
									if (keep_frame) begin
										pend_valid_reg <= 1'b1;
										pend_word_reg <= {ovr_reg, ~vote, rx_upe, rx_data9};
										ovr_reg <= 1'b0;
									end
								end
								default: rx_state_reg <= RX_IDLE;
							endcase
						end
					end
					default: rx_state_reg <= RX_IDLE;
				endcase
			end
		end
	end

	// registered read data; flags describe the frame at the buffer head
	always @(posedge clock) begin
		if (srst) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				`ADDR_DATA: io_rdata <= head_valid ? head_word[7:0] : 8'h00;
				`ADDR_CTRL_A: io_rdata <= {head_valid, txc_reg, ~thr_valid_reg,
					head_valid & head_word[`W_FE], head_valid & head_word[`W_DOR],
					head_valid & head_word[`W_UPE], u2x_reg, mpcm_reg};
				`ADDR_CTRL_B: io_rdata <= {3'h0, rxen_reg, txen_reg, ucsz_reg[2],
					head_valid & head_word[`W_B8], tx_b8_reg};
				`ADDR_CTRL_C: io_rdata <= {2'h0, upm_reg, usbs_reg, ucsz_reg[1:0], 1'b0};
				`ADDR_BAUD_LO: io_rdata <= baud_reg[7:0];
				`ADDR_BAUD_HI: io_rdata <= {4'h0, baud_reg[11:8]};
				default: io_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### test/serial_line_model.sv
/*
 Far-end transmitter that drives the receive pin of the serial port.
 Assumes the caller picks clocks per bit; divisor 0 gives one tick a clock.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
	input wire logic clock,
	output logic line
);
	// idle level is high
	initial line = 1'b1;

	// start, n bits lsb first (type bit included), one closing stop, exact rate
	task automatic send(input logic [9:0] bits, input int n, input int bc);
		int i;
		@(posedge clock);
		#1 line = 1'b0;
		repeat (bc) @(posedge clock);
		for (i = 0; i < n; i++) begin
			#1 line = bits[i];
			repeat (bc) @(posedge clock);
		end
		#1 line = 1'b1;
		repeat (bc) @(posedge clock);
	endtask

	// short low pulse on an idle line, too brief to pass the start vote
	task automatic spike(input int w);
		@(posedge clock);
		#1 line = 1'b0;
		repeat (w) @(posedge clock);
		#1 line = 1'b1;
	endtask
endmodule
`default_nettype wire

// ### test/usart_checker_properties.sv
/*
 Port-level properties of the serial port.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module usart_checker (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic serial_rx_pin,
	input wire logic serial_tx_pin,
	input wire logic txc_irq_ack
);
	logic [1:0] a_low_reg;
	logic [2:0] size_reg;
	logic tx_used_reg;

	default clocking @(posedge clock);
	endclocking

	// shadow of the written control fields
	always @(posedge clock) begin
		if (srst) begin
			a_low_reg <= 2'b00;
			size_reg <= 3'h3;
			tx_used_reg <= 1'b0;
		end else if (io_wr && io_addr == 8'h00) begin
			a_low_reg <= io_wdata[1:0];
		end else if (io_wr && io_addr == 8'h01) begin
			size_reg[2] <= io_wdata[2];
			tx_used_reg <= tx_used_reg | io_wdata[3];
		end else if (io_wr && io_addr == 8'h02) begin
			size_reg[1:0] <= io_wdata[2:1];
		end
	end

	reset_outputs_a: assert property (srst |=> io_rdata == 8'h00 && serial_tx_pin)
		else $error("outputs not at reset level");
	rdata_holds_a: assert property (disable iff (srst) !io_rd |=> $stable(io_rdata))
		else $error("read data changed without a read");
	unmapped_zero_a: assert property (disable iff (srst) io_rd && (io_addr == 8'h03 || io_addr > 8'h06) |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	status_reset_a: assert property (disable iff (srst) $past(srst) && io_rd && io_addr == 8'h00 |=> io_rdata == 8'h20)
		else $error("status after reset wrong");
	upper_zero_a: assert property (disable iff (srst) io_rd && io_addr == 8'h06 && size_reg < 3'h3
		|=> (io_rdata & (8'hFF << (5 + size_reg))) == 8'h00)
		else $error("unused data bits not zero");
	ctrl_echo_a: assert property (disable iff (srst) io_rd && io_addr == 8'h00 |=> io_rdata[1:0] == $past(a_low_reg))
		else $error("speed or filter bit lost");
	bit_length_a: assert property (disable iff (srst) $changed(serial_tx_pin) |=> $stable(serial_tx_pin) [*7])
		else $error("transmit bit too short");
	tx_quiet_a: assert property (disable iff (srst) !tx_used_reg |-> serial_tx_pin)
		else $error("transmit pin active while disabled");
endmodule

bind usart_rx_address_filter_data_buffer usart_checker u_checker (.clock(clock), .srst(srst), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .serial_rx_pin(serial_rx_pin),
	.serial_tx_pin(serial_tx_pin), .txc_irq_ack(txc_irq_ack));
`default_nettype wire

// ### test/tb.sv
/*
 Self-checking bench: receive cases from a table, then reset, buffer and transmit cases.
 Assumes divisor 0 unless a case sets it, so a bit lasts 16 clocks, or 8 in double speed.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic [2:0] cs; logic u2x; logic mpcm; logic [9:0] bits; logic st; logic [7:0] exp;} row_t;
	localparam logic [15:0] FSEQ [0:5] = '{16'h00A0, 16'h0611, 16'h0622, 16'h00A8, 16'h0644, 16'h0020};
	logic clock, srst, io_wr, io_rd, txc_irq_ack;
	logic [7:0] io_addr, io_wdata;
	wire [7:0] io_rdata;
	wire serial_rx_pin, serial_tx_pin;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	row_t rows [0:7];

	usart_rx_address_filter_data_buffer dut (.clock(clock), .srst(srst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .serial_rx_pin(serial_rx_pin),
		.serial_tx_pin(serial_tx_pin), .txc_irq_ack(txc_irq_ack));
	serial_line_model model (.clock(clock), .line(serial_rx_pin));

	// clock and hang guard
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			conclude();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clock);
		#1 io_wr = 1'b0;
		@(posedge clock);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd = 1'b1;
		@(posedge clock);
		#1 io_rd = 1'b0;
		@(posedge clock);
		#1 d = io_rdata;
	endtask

	// sample one 8-bit frame from the transmit pin at mid-bit
	task automatic cap(output logic [7:0] d);
		int k;
		k = 0;
		while (serial_tx_pin !== 1'b0 && k < 400) begin
			@(posedge clock);
			#1 k++;
		end
		repeat (8) @(posedge clock);
		for (k = 0; k < 8; k++) begin
			repeat (16) @(posedge clock);
			#1 d[k] = serial_tx_pin;
		end
		repeat (16) @(posedge clock);
		#1;
	endtask

	task automatic reset_check;
		logic [7:0] v;
		srst = 1'b1;
		repeat (2) @(posedge clock);
		#1 srst = 1'b0;
		rd(8'h00, v);
		chk(v, 8'h20);
		rd(8'h02, v);
		chk(v, 8'h06);
		wr(8'h03, 8'hFF);
		rd(8'h03, v);
		chk(v, 8'h00);
		rd(8'h40, v);
		chk(v, 8'h00);
	endtask

	task automatic conclude;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		row_t r;
		logic [7:0] v;
		int i, n;
		clock = 1'b0;
		srst = 1'b1;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		txc_irq_ack = 1'b0;
		rows[0] = {3'h3, 2'b00, 10'h1A5, 1'b1, 8'hA5};
		rows[1] = {3'h0, 2'b10, 10'h036, 1'b1, 8'h16};
		rows[2] = {3'h1, 2'b01, 10'h06B, 1'b1, 8'h2B};
		rows[3] = {3'h2, 2'b01, 10'h055, 1'b0, 8'h00};
		rows[4] = {3'h7, 2'b01, 10'h33C, 1'b1, 8'h3C};
		rows[5] = {3'h7, 2'b01, 10'h25A, 1'b0, 8'h00};
		rows[6] = {3'h7, 2'b00, 10'h2C7, 1'b1, 8'hC7};
		rows[7] = {3'h3, 2'b11, 10'h1C3, 1'b1, 8'hC3};
		reset_check();
		for (i = 0; i < 8; i++) begin
			r = rows[i];
			wr(8'h00, {6'h00, r.u2x, r.mpcm});
			wr(8'h01, {3'h0, 2'b11, r.cs[2], 2'b00});
			wr(8'h02, {5'h00, r.cs[1:0], 1'b0});
			model.send(r.bits, (r.cs == 3'h7) ? 10 : 6 + r.cs, r.u2x ? 8 : 16);
			repeat (4) @(posedge clock);
			#1 rd(8'h00, v);
			chk(v, {r.st, 5'h08, r.u2x, r.mpcm});
			if (r.st) begin
				rd(8'h01, v);
				if (r.cs == 3'h7) chk({7'h00, v[1]}, {7'h00, r.bits[8]});
				rd(8'h06, v);
				chk(v, r.exp);
				rd(8'h00, v);
				chk(v, {6'h08, r.u2x, r.mpcm});
			end
		end
		// divisor 1, odd parity, two stop bits: a noise spike, then good and bad parity frames
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h01);
		wr(8'h02, 8'h3E);
		model.spike(4);
		repeat (64) @(posedge clock);
		#1 rd(8'h00, v);
		chk(v, 8'h20);
		for (i = 0; i < 2; i++) begin
			model.send({1'b1, ~i[0], 8'hA5}, 10, 32);
			repeat (8) @(posedge clock);
			#1 rd(8'h00, v);
			chk(v, {5'h14, i[0], 2'b00});
			rd(8'h06, v);
			chk(v, 8'hA5);
		end
		// second reset, then two-level buffer with an overrun
		reset_check();
		wr(8'h01, 8'h18);
		for (i = 1; i < 5; i++) model.send({2'b01, i[3:0], i[3:0]}, 9, 16);
		repeat (4) @(posedge clock);
		#1;
		for (i = 0; i < 6; i++) begin
			rd(FSEQ[i][15:8], v);
			chk(v, FSEQ[i][7:0]);
		end
		// transmit with the filter on: two frames sent, third write dropped
		wr(8'h00, 8'h01);
		fork
			begin
				cap(v);
				chk(v, 8'h5A);
				cap(v);
				chk(v, 8'h77);
			end
			begin
				wr(8'h06, 8'h5A);
				wr(8'h06, 8'h77);
				wr(8'h06, 8'h99);
			end
		join
		n = 0;
		repeat (200) begin
			@(posedge clock);
			#1;
			if (serial_tx_pin !== 1'b1) n++;
		end
		chk(n[7:0], 8'h00);
		rd(8'h00, v);
		chk(v, 8'h61);
		wr(8'h00, 8'h41);
		rd(8'h00, v);
		chk(v, 8'h21);
		wr(8'h06, 8'h3C);
		repeat (200) @(posedge clock);
		#1 rd(8'h00, v);
		chk(v, 8'h61);
		txc_irq_ack = 1'b1;
		@(posedge clock);
		#1 txc_irq_ack = 1'b0;
		rd(8'h00, v);
		chk(v, 8'h21);
		conclude();
	end
endmodule
`default_nettype wire
